// [common/fpc_pkg.sv]
// package: constants and types for the flash program/erase parameter checker
package fpc_pkg;
    localparam logic [7:0] KEY_OK_VALUE = 8'h5A;
    localparam int BIT_SF = 0;
    localparam int BIT_WA = 1;
    localparam int BIT_WD = 2;
    localparam int BIT_EB = 3;
    localparam int BIT_FK = 4;
    localparam int BIT_EE = 5;
    localparam int BIT_MD = 6;
    localparam int BIT_RSV7 = 7;
    localparam logic [6:0] ALIGN_MASK = 7'h7F;
    localparam logic [7:0] BLOCK_MAX = 8'h0F;
    localparam logic [31:0] FLASH_BASE = 32'h00000000;
    localparam logic [31:0] FLASH_LAST = 32'h0003FFFF;
    localparam logic [31:0] ROUTINE_RAM_BASE = 32'h00FF0800;
    localparam logic [31:0] ROUTINE_RAM_LAST = 32'h00FF17FF;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    typedef enum logic [1:0] {
        FPC_IDLE = 2'b00,
        FPC_CHECK = 2'b01,
        FPC_ACT = 2'b10,
        FPC_DONE = 2'b11
    } fpc_state_t;
endpackage

// [common/fpc_chk_if.sv]
// interface: operands and flags between top and the checker
`timescale 1ns/1ps
interface fpc_chk_if;
    logic is_erase;
    logic [7:0] key;
    logic prot;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] blk_sel;
    logic [7:0] flags;
    modport top (output is_erase, key, prot, src, dst, blk_sel, input flags);
    modport chk (input is_erase, key, prot, src, dst, blk_sel, output flags);
endinterface

// [hdl/fpc_check.sv]
// combinational parameter checker producing error flags
`timescale 1ns/1ps
module fpc_check (
    fpc_chk_if.chk c
);
    import fpc_pkg::*;

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        c.flags = RESULT_RESET;
        c.flags[BIT_FK] = (c.key != KEY_OK_VALUE);
        c.flags[BIT_MD] = c.prot;
        if (c.is_erase) begin
            // only the low byte is the block number; upper bits are ignored
            c.flags[BIT_EB] = (c.blk_sel[7:0] > BLOCK_MAX);
        end else begin
            c.flags[BIT_WD] = in_range(c.src, FLASH_BASE, FLASH_LAST)
                || in_range(c.src, ROUTINE_RAM_BASE, ROUTINE_RAM_LAST);
            c.flags[BIT_WA] = !in_range(c.dst, FLASH_BASE, FLASH_LAST)
                || ((c.dst[6:0] & ALIGN_MASK) != 7'h00);
        end
    end
endmodule

// [hdl/fpc_top.sv]
// top: flash program/erase parameter check and result encoding
`timescale 1ns/1ps
// Functional notes
// - before programming, key bit 4 set when key differs from 5A
// - programming result bits 3 and 7 always read zero
// - bit 2 set when source lies in flash or routine RAM
// - bit 1 set when destination lies outside flash
// - bit 1 also set when destination low seven bits nonzero
// - bit 0 reports program outcome, 1 on abnormal end
// - block number in bits 7..0, values 0..15 pick one block
// - block numbers above 15 are errors and nothing is erased
// - erase result byte has bit 7 zero
// - before erase, key bit 4 set when key differs from 5A
// - erase bit 3 set when block number out of range
// - erase bit 0 reports outcome; bits 2 and 1 read zero
// - bit 6 set when flash error protection is active
module fpc_top (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic prog_req_in,
    input wire logic erase_req_in,
    input wire logic [7:0] flash_key_value_in,
    input wire logic flash_error_protect_state_in,
    input wire logic [31:0] src_addr_in,
    input wire logic [31:0] dst_addr_in,
    input wire logic [31:0] erase_block_select_in,
    input wire logic op_fail_in,
    output logic [7:0] op_pass_fail_result_out,
    output logic done_out,
    output logic busy_out,
    output logic prog_start_out,
    output logic erase_start_out,
    output logic [3:0] erase_block_number_out
);
    import fpc_pkg::*;

    fpc_chk_if c ();
    fpc_state_t state_ff, nxt_state;
    logic is_erase_ff, nxt_is_erase;
    logic [7:0] key_ff, nxt_key;
    logic prot_ff, nxt_prot;
    logic [31:0] src_ff, nxt_src;
    logic [31:0] dst_ff, nxt_dst;
    logic [31:0] blk_ff, nxt_blk;
    logic [7:0] result_ff, nxt_result;
    logic done_ff, nxt_done;
    logic busy_ff, nxt_busy;
    logic pstart_ff, nxt_pstart;
    logic estart_ff, nxt_estart;
    logic [3:0] bnum_ff, nxt_bnum;
    logic any_err;
    logic take_req;
    logic chk_fail;
    logic chk_pass;
    logic finish_op;

    assign c.is_erase = is_erase_ff;
    assign c.key = key_ff;
    assign c.prot = prot_ff;
    assign c.src = src_ff;
    assign c.dst = dst_ff;
    assign c.blk_sel = blk_ff;

    fpc_check u_check (
        .c(c)
    );

    // reserved bits never reach the result since the checker leaves them zero
    assign any_err = |c.flags;

    // a request raised while busy is dropped without any indication
    assign take_req = (state_ff == FPC_IDLE) && (prog_req_in || erase_req_in);
    assign chk_fail = (state_ff == FPC_CHECK) && any_err;
    assign chk_pass = (state_ff == FPC_CHECK) && !any_err;
    assign finish_op = (state_ff == FPC_DONE);

    // reserved positions forced low here too, so a checker change cannot leak them
    function automatic logic [7:0] error_result(input logic [7:0] flags, input logic erase_op);
        error_result = flags;
        error_result[BIT_RSV7] = 1'b0;
        error_result[BIT_EE] = 1'b0;
        if (erase_op) begin
            error_result[BIT_WD] = 1'b0;
            error_result[BIT_WA] = 1'b0;
        end else begin
            error_result[BIT_EB] = 1'b0;
        end
        error_result[BIT_SF] = 1'b1;
    endfunction

    // a clean finish carries only the engine's verdict
    function automatic logic [7:0] done_result(input logic fail);
        done_result = RESULT_RESET;
        done_result[BIT_SF] = fail;
    endfunction

    // sequencer: phase, busy level and the one-cycle strobes
    always_comb begin
        nxt_state = state_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_pstart = 1'b0;
        nxt_estart = 1'b0;
        case (state_ff)
            FPC_IDLE: begin
                if (take_req) begin
                    nxt_busy = 1'b1;
                    nxt_state = FPC_CHECK;
                end
            end
            FPC_CHECK: begin
                if (chk_fail) begin
                    // skip the action entirely on any parameter error
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = FPC_IDLE;
                end else begin
                    nxt_pstart = !is_erase_ff;
                    nxt_estart = is_erase_ff;
                    nxt_state = FPC_ACT;
                end
            end
            FPC_ACT: begin
                nxt_state = FPC_DONE;
            end
            FPC_DONE: begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = FPC_IDLE;
            end
            default: begin
                nxt_busy = 1'b0;
                nxt_state = FPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_ff <= FPC_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pstart_ff <= 1'b0;
            estart_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            pstart_ff <= nxt_pstart;
            estart_ff <= nxt_estart;
        end
    end

    // operands are frozen at the taking edge so the caller may move on
    always_comb begin
        nxt_is_erase = is_erase_ff;
        nxt_key = key_ff;
        nxt_prot = prot_ff;
        nxt_src = src_ff;
        nxt_dst = dst_ff;
        nxt_blk = blk_ff;
        if (take_req) begin
            // program wins if both requests arrive together
            nxt_is_erase = !prog_req_in;
            nxt_key = flash_key_value_in;
            nxt_prot = flash_error_protect_state_in;
            nxt_src = src_addr_in;
            nxt_dst = dst_addr_in;
            nxt_blk = erase_block_select_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            is_erase_ff <= 1'b0;
            key_ff <= 8'h00;
            prot_ff <= 1'b0;
            src_ff <= 32'h00000000;
            dst_ff <= 32'h00000000;
            blk_ff <= 32'h00000000;
        end else begin
            is_erase_ff <= nxt_is_erase;
            key_ff <= nxt_key;
            prot_ff <= nxt_prot;
            src_ff <= nxt_src;
            dst_ff <= nxt_dst;
            blk_ff <= nxt_blk;
        end
    end

    // result byte and block number hold until the next update
    always_comb begin
        nxt_result = result_ff;
        nxt_bnum = bnum_ff;
        if (chk_fail) begin
            nxt_result = error_result(c.flags, is_erase_ff);
        end else if (chk_pass) begin
            nxt_bnum = blk_ff[3:0];
        end else if (finish_op) begin
            // engine reports completion level; zero means clean finish
            nxt_result = done_result(op_fail_in);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            result_ff <= RESULT_RESET;
            bnum_ff <= 4'h0;
        end else begin
            result_ff <= nxt_result;
            bnum_ff <= nxt_bnum;
        end
    end

    assign op_pass_fail_result_out = result_ff;
    assign done_out = done_ff;
    assign busy_out = busy_ff;
    assign prog_start_out = pstart_ff;
    assign erase_start_out = estart_ff;
    assign erase_block_number_out = bnum_ff;
endmodule

// [bench/fpc_top_props.sv]
// checker: timing and result-bit properties of the parameter checker
`timescale 1ns/1ps
module fpc_top_props import fpc_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic prog_req_in,
    input wire logic erase_req_in,
    input wire logic [7:0] flash_key_value_in,
    input wire logic flash_error_protect_state_in,
    input wire logic [31:0] src_addr_in,
    input wire logic [31:0] dst_addr_in,
    input wire logic [31:0] erase_block_select_in,
    input wire logic op_fail_in,
    input wire logic [7:0] op_pass_fail_result_out,
    input wire logic done_out,
    input wire logic busy_out,
    input wire logic prog_start_out,
    input wire logic erase_start_out,
    input wire logic [3:0] erase_block_number_out
);
    logic tp, te;
    logic [7:0] r;
    // prog wins when both requests arrive together
    assign tp = prog_req_in & ~busy_out;
    assign te = erase_req_in & ~prog_req_in & ~busy_out;
    assign r = op_pass_fail_result_out;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    AST_KEY: assert property ((tp || te) && flash_key_value_in != KEY_OK_VALUE |-> ##2 done_out && r[4] && r[0])
        else $error("key error not flagged");
    AST_RSV: assert property (done_out |-> !r[7] && !r[5])
        else $error("reserved result bit set");
    AST_SRC: assert property (tp && src_addr_in <= FLASH_LAST |-> ##2 done_out && r[2] && r[0])
        else $error("source error not flagged");
    AST_ALIGN: assert property (tp && dst_addr_in[6:0] != 7'h00 |-> ##1 !prog_start_out ##1 done_out && r[1] && !prog_start_out)
        else $error("alignment error not flagged");
    AST_DST: assert property (tp && dst_addr_in > FLASH_LAST |-> ##2 done_out && r[1])
        else $error("destination range error not flagged");
    AST_BLK: assert property (te && erase_block_select_in[7:0] > BLOCK_MAX |-> ##2 done_out && r[3] && !erase_start_out)
        else $error("block range error not flagged");
    AST_PROT: assert property ((tp || te) && flash_error_protect_state_in |-> ##2 done_out && r[6])
        else $error("protection error not flagged");
    AST_ERA: assert property (te && flash_key_value_in == KEY_OK_VALUE && !flash_error_protect_state_in
        && erase_block_select_in[7:0] <= BLOCK_MAX |-> ##2 erase_start_out
        && erase_block_number_out == $past(erase_block_select_in[3:0], 2) ##2 done_out && r[7:1] == 7'h00)
        else $error("clean erase mishandled");
    AST_SF: assert property (done_out && $past(prog_start_out, 2) |-> r == {7'h00, $past(op_fail_in)})
        else $error("outcome bit wrong");
    cover property (done_out && r[0]);
    cover property (prog_start_out);
    cover property (erase_start_out);
endmodule
bind fpc_top fpc_top_props u_props (.sys_clk_in, .rst_in, .prog_req_in, .erase_req_in, .flash_key_value_in,
    .flash_error_protect_state_in, .src_addr_in, .dst_addr_in, .erase_block_select_in, .op_fail_in,
    .op_pass_fail_result_out, .done_out, .busy_out, .prog_start_out, .erase_start_out, .erase_block_number_out);

// [bench/fpc_top_tb.sv]
// testbench: program and erase parameter checks
`timescale 1ns/1ps
module fpc_top_tb;
    import fpc_pkg::*;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, prog_req_in = 1'b0, erase_req_in = 1'b0;
    logic flash_error_protect_state_in = 1'b0, op_fail_in = 1'b0;
    logic [7:0] flash_key_value_in = 8'h00;
    logic [31:0] src_addr_in = 32'h0, dst_addr_in = 32'h0, erase_block_select_in = 32'h0;
    logic [7:0] op_pass_fail_result_out;
    logic done_out, busy_out, prog_start_out, erase_start_out;
    logic [3:0] erase_block_number_out;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    logic [7:0] r;
    logic s;
    logic [3:0] b;
    fpc_top DUT (.sys_clk_in, .rst_in, .prog_req_in, .erase_req_in, .flash_key_value_in,
        .flash_error_protect_state_in, .src_addr_in, .dst_addr_in, .erase_block_select_in, .op_fail_in,
        .op_pass_fail_result_out, .done_out, .busy_out, .prog_start_out, .erase_start_out, .erase_block_number_out);
    always #12.5 sys_clk_in = ~sys_clk_in;
    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // whole run needs about 110 cycles
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc > 2000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    // request pulse for one cycle, then bounded wait for done
    task automatic op(input logic p, input logic e, input logic [7:0] k, input logic pr, input logic [31:0] sa,
        input logic [31:0] da, input logic [31:0] bs, input logic f);
        int i;
        @(negedge sys_clk_in);
        {prog_req_in, erase_req_in, flash_key_value_in, flash_error_protect_state_in} = {p, e, k, pr};
        {src_addr_in, dst_addr_in, erase_block_select_in, op_fail_in} = {sa, da, bs, f};
        @(negedge sys_clk_in);
        prog_req_in = 1'b0;
        erase_req_in = 1'b0;
        s = 1'b0;
        chk({7'h00, busy_out}, 8'h01);
        for (i = 0; i < 8 && done_out !== 1'b1; i++) begin
            if (prog_start_out === 1'b1 || erase_start_out === 1'b1) begin
                s = 1'b1;
                b = erase_block_number_out;
            end
            @(negedge sys_clk_in);
        end
        r = op_pass_fail_result_out;
        chk({6'h00, done_out, busy_out}, 8'h02);
        chk(i[7:0], s ? 8'h03 : 8'h01);
    endtask
    task automatic t_prog;
        op(1'b1, 1'b0, 8'h5A, 1'b0, 32'h00FF2000, 32'h00000100, 32'h0, 1'b0);
        chk(r, 8'h00);
        chk({7'h00, s}, 8'h01);
        op(1'b1, 1'b0, 8'h5A, 1'b0, 32'h00FF2000, 32'h00000100, 32'h0, 1'b1);
        chk(r, 8'h01);
        op(1'b1, 1'b1, 8'h00, 1'b1, 32'h00000000, 32'h00000101, 32'h0, 1'b0);
        chk(r, 8'h57);
        chk({7'h00, s}, 8'h00);
        op(1'b1, 1'b0, 8'h5A, 1'b0, 32'h00FF0800, 32'h00040000, 32'h0, 1'b0);
        chk(r, 8'h07);
    endtask
    task automatic t_erase;
        for (int i = 0; i < 16; i++) begin
            op(1'b0, 1'b1, 8'h5A, 1'b0, 32'h0, 32'h0, i, 1'b0);
            chk(r, 8'h00);
            chk({3'h0, s, b}, 8'h10 | i[7:0]);
        end
        op(1'b0, 1'b1, 8'h5A, 1'b0, 32'h0, 32'h0, 32'h10, 1'b1);
        chk({s, r[6:0]}, 8'h09);
        op(1'b0, 1'b1, 8'h00, 1'b1, 32'h0, 32'h0, 32'hFF, 1'b0);
        chk(r, 8'h59);
        op(1'b0, 1'b1, 8'h5A, 1'b0, 32'h0, 32'h0, 32'h3, 1'b1);
        chk(r, 8'h01);
    endtask
    initial begin
        repeat (2) @(negedge sys_clk_in);
        rst_in = 1'b0;
        chk(op_pass_fail_result_out, RESULT_RESET);
        t_prog;
        t_erase;
        finish_test;
    end
endmodule
